/* src/bcu_top.sv */
// Purpose : Sequencer for the bit-and-with-carry instruction (logic_and_op).
// Assumes : Bit memory answers on the same clock with bitRdValid.
// Notes   : A bit read that never answers aborts after a timeout.
`timescale 1ns/10ps
`default_nettype none

module bcu_top
  import bcu_pkg::*;
#(
  parameter logic [7:0] OPC_PLAIN  = 8'h82,
  parameter int         RD_TIMEOUT = BCU_RD_TIMEOUT
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       codeValid,
  input  wire logic [7:0] codeByte,
  output logic            codeReady,
  output logic            bitRdReq,
  output logic [7:0]      bitRdAddr,
  input  wire logic       bitRdValid,
  input  wire logic       bitRdData,
  input  wire logic       carryIn,
  output logic            carryWrEn,
  output logic            carryWrData,
  output logic            opBusy,
  output logic            opDone,
  output logic            opError
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  bcu_state_t state_reg;
  bcu_state_t state_next;
  logic       invert_reg;
  logic       srcBit_reg;
  logic [4:0] tmo_reg;
  logic       codeTake;
  logic       isPlain;
  logic       isInv;
  logic       carryNew;
  logic       tmoHit;

  assign codeTake = codeValid & codeReady;
  assign isPlain  = (codeByte == OPC_PLAIN);
  assign isInv    = (codeByte == BCU_OPC_INV);  // see RL7
  assign tmoHit   = (tmo_reg == 5'(RD_TIMEOUT - 1));

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BCU_IDLE: begin
        // Bytes of other instructions are ignored here
        if (codeTake && (isPlain || isInv)) begin
          state_next = BCU_ADDR;
        end
      end
      BCU_ADDR: begin
        // Second byte is always a direct bit address
        if (codeTake) begin
          state_next = BCU_READ;  // see RL6
        end
      end
      BCU_READ: begin
        if (bitRdValid) begin
          state_next = BCU_WRITE;
        end else if (tmoHit) begin
          state_next = BCU_IDLE;
        end
      end
      BCU_WRITE: begin
        state_next = BCU_IDLE;
      end
      default: begin
        state_next = BCU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BCU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Code byte handshake
  // ***************************************************************
  // Ready only while waiting for a code byte; stalls the decoder otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codeReady <= 1'b1;
    end else begin
      codeReady <= (state_next == BCU_IDLE) || (state_next == BCU_ADDR);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      invert_reg <= 1'b0;
    end else if (state_reg == BCU_IDLE && codeTake && (isPlain || isInv)) begin
      invert_reg <= isInv;  // see RL3 see RL7
    end
  end

  // ***************************************************************
  // Bit read, never a write back to the source
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitRdAddr <= 8'h00;
    end else if (state_reg == BCU_ADDR && codeTake) begin
      bitRdAddr <= codeByte;  // see RL6 see RL8
    end
  end

  // Request held until the bit memory answers or the read times out; no write strobe exists
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitRdReq <= 1'b0;
    end else begin
      bitRdReq <= (state_next == BCU_READ);  // see RL4 see RL8
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srcBit_reg <= 1'b0;
    end else if (state_reg == BCU_READ && bitRdValid) begin
      srcBit_reg <= bitRdData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmo_reg <= BCU_TMO_RST;
    end else if (state_reg == BCU_READ) begin
      tmo_reg <= tmo_reg + 5'h01;
    end else begin
      tmo_reg <= BCU_TMO_RST;
    end
  end

  // ***************************************************************
  // Carry update
  // ***************************************************************
  // Carry is sampled at write time so an earlier update is not lost
  bcu_carry_logic u_carry (
    .carryOld (carryIn),
    .srcBit   (srcBit_reg),
    .invert   (invert_reg),
    .carryNew (carryNew)
  );

  // Only the carry flag has a write port here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carryWrEn   <= 1'b0;
      carryWrData <= 1'b0;
    end else begin
      carryWrEn   <= (state_reg == BCU_WRITE);  // see RL5 see RL8
      carryWrData <= carryNew;  // see RL1 see RL2
    end
  end

  // ***************************************************************
  // Status
  // ***************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opBusy <= 1'b0;
    end else begin
      opBusy <= (state_next != BCU_IDLE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opDone <= 1'b0;
    end else begin
      opDone <= (state_reg == BCU_WRITE);
    end
  end

  // Aborted read leaves carry untouched
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opError <= 1'b0;
    end else begin
      opError <= (state_reg == BCU_READ) && !bitRdValid && tmoHit;
    end
  end

endmodule

`default_nettype wire

/* src/bcu_pkg.sv */
// Purpose : Shared constants for the bit-and carry unit of the 8-bit core.
// Assumes : One core clock; the decoder hands over code bytes one at a time.
// Notes   : Other instructions pass through this block untouched.
//
// How it works
// RL1: A source value of zero clears the carry flag.
// RL2: A source value of one leaves the carry flag as it was.
// RL3: The complemented form uses the inverse of the addressed bit.
// RL4: The addressed source bit is only read, never written back.
// RL5: Only the carry flag is written; no other status flag changes.
// RL6: The source operand is always a direct bit address from the code stream.
// RL7: Complemented form is opcode 1011_0000 plus address byte; 2 bytes, 2 cycles; the sequencer takes at least 4 (IDLE, ADDR, READ, WRITE).
// RL8: Read the bit at the 8-bit bit address, write only carry at the end.

package bcu_pkg;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  localparam logic [7:0] BCU_OPC_INV   = 8'hB0;
  localparam int         BCU_OP_BYTES  = 2;
  localparam int         BCU_OP_CYCLES = 2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int         BCU_RD_TIMEOUT = 16;
  localparam logic [4:0] BCU_TMO_RST    = 5'h00;

  // ***************************************************************
  // Sequencer states, Gray along the usual path
  // ***************************************************************
  typedef enum logic [1:0] {
    BCU_IDLE  = 2'b00,
    BCU_ADDR  = 2'b01,
    BCU_READ  = 2'b11,
    BCU_WRITE = 2'b10
  } bcu_state_t;

  // Selects the source value: the bit itself or its complement
  function automatic logic bcu_src_value(input logic bitVal, input logic invert);
    return bitVal ^ invert;
  endfunction

endpackage

/* src/bcu_carry_logic.sv */
// Purpose : Carry update for the bit-and operation.
// Assumes : Inputs are stable in the cycle the result is used.
// Notes   : Pure combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none

module bcu_carry_logic
  import bcu_pkg::*;
(
  input  wire logic carryOld,
  input  wire logic srcBit,
  input  wire logic invert,
  output logic      carryNew
);

  logic srcVal;

  assign srcVal = bcu_src_value(srcBit, invert);  // see RL3

  // Zero clears, one keeps the old carry
  assign carryNew = carryOld & srcVal;  // see RL1 see RL2

endmodule

`default_nettype wire

/* tb/bcu_properties.sv */
// Purpose : Timing checks on the bit-and carry unit ports.
// Assumes : Opcode and address arrive as a byte pair.
// Notes   : Watches design inputs and outputs only.
`timescale 1ns/10ps
`default_nettype none
module bcu_properties
  import bcu_pkg::*;
#(
  parameter logic [7:0] OPC_PLAIN  = 8'h82,
  parameter int         RD_TIMEOUT = BCU_RD_TIMEOUT
)
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       codeValid,
  input wire logic [7:0] codeByte,
  input wire logic       codeReady,
  input wire logic       bitRdReq,
  input wire logic [7:0] bitRdAddr,
  input wire logic       bitRdValid,
  input wire logic       bitRdData,
  input wire logic       carryIn,
  input wire logic       carryWrEn,
  input wire logic       carryWrData,
  input wire logic       opBusy
);
  // ****
  // Opcode tracking
  // ****
  logic haveOp_reg;
  logic inv_reg;
  logic take;
  logic rd;
  logic known;
  assign take  = codeValid && codeReady;
  assign rd    = bitRdReq && bitRdValid;
  assign known = codeByte == OPC_PLAIN || codeByte == BCU_OPC_INV;
  // The form must be remembered: the read answer comes long after the opcode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      haveOp_reg <= 1'b0;
      inv_reg    <= 1'b0;
    end else if (take) begin
      haveOp_reg <= !haveOp_reg && known;
      if (!haveOp_reg) inv_reg <= codeByte == BCU_OPC_INV;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_clear_on_zero: assert property (rd && !(bitRdData ^ inv_reg) |-> ##2 carryWrEn && !carryWrData)
    else $error("carry not cleared");
  a_keep_on_one: assert property (rd && (bitRdData ^ inv_reg) |-> ##2 carryWrEn && carryWrData == $past(carryIn))
    else $error("carry not kept");
  a_inv_source: assert property (rd && inv_reg && bitRdData |-> ##2 carryWrEn && !carryWrData)
    else $error("complement not used");
  a_write_once: assert property (carryWrEn |=> !carryWrEn && !opBusy)
    else $error("extra carry write");
  a_direct_addr: assert property (take && haveOp_reg |=> bitRdReq && bitRdAddr == $past(codeByte))
    else $error("bit address not direct");
  a_two_byte_op: assert property (take && !haveOp_reg && known |=> codeReady && opBusy)
    else $error("opcode not accepted");
  a_bad_op_ignored: assert property (take && !haveOp_reg && !known |=> !opBusy)
    else $error("foreign opcode taken");
  a_read_then_write: assert property (rd |=> !bitRdReq ##1 carryWrEn)
    else $error("read not followed by write");
endmodule
bind bcu_top bcu_properties #(.OPC_PLAIN(OPC_PLAIN), .RD_TIMEOUT(RD_TIMEOUT)) bcu_properties_i (
  .clk(clk), .nrst(nrst), .codeValid(codeValid), .codeByte(codeByte), .codeReady(codeReady),
  .bitRdReq(bitRdReq), .bitRdAddr(bitRdAddr), .bitRdValid(bitRdValid), .bitRdData(bitRdData),
  .carryIn(carryIn), .carryWrEn(carryWrEn), .carryWrData(carryWrData), .opBusy(opBusy));
`default_nettype wire

/* tb/test_bit_and_carry_unit.sv */
// Purpose : Self-checking bench for the bit-and carry unit.
// Assumes : Inputs change on the falling clock edge.
// Notes   : Short read timeout keeps the abort case brief.
`timescale 1ns/10ps
`default_nettype none
module test_bit_and_carry_unit
  import bcu_pkg::*;
;
  logic clk, nrst, codeValid, bitRdValid, bitRdData, carryIn;
  logic codeReady, bitRdReq, carryWrEn, carryWrData, opBusy, opDone, opError;
  logic [7:0] codeByte, bitRdAddr;
  int miscompares, n_tests;
  bcu_top #(.RD_TIMEOUT(4)) bcu_top_i (.clk(clk), .nrst(nrst), .codeValid(codeValid),
    .codeByte(codeByte), .codeReady(codeReady), .bitRdReq(bitRdReq), .bitRdAddr(bitRdAddr),
    .bitRdValid(bitRdValid), .bitRdData(bitRdData), .carryIn(carryIn), .carryWrEn(carryWrEn),
    .carryWrData(carryWrData), .opBusy(opBusy), .opDone(opDone), .opError(opError));
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] adr, input logic d, input logic c,
                     input int dly);
    carryIn   = c;
    codeValid = 1'b1;
    codeByte  = op;
    @(negedge clk) codeByte = adr;
    @(negedge clk) codeValid = 1'b0;
    codeByte = ~adr;
    repeat (dly) @(negedge clk);
    chk("addr", bitRdAddr, adr);
    bitRdValid = 1'b1;
    bitRdData  = d;
    @(negedge clk) bitRdValid = 1'b0;
    // Released data line flips so a stale sample shows up
    bitRdData = ~d;
    chk("rdrop", bitRdReq, 1'b0);
    @(negedge clk);
    chk("wr", {opError, carryWrEn, opDone, opBusy, codeReady}, 5'h0D);
    chk("carry", carryWrData, c & (d ^ (op == BCU_OPC_INV)));
    @(negedge clk);
    chk("pulse", carryWrEn, 1'b0);
  endtask
  task automatic t_truth();
    for (int i = 0; i < 8; i++) run(i[2] ? 8'hB0 : 8'h82, 8'h20 + i[7:0], i[1], i[0], 0);
  endtask
  task automatic t_slow();
    run(8'hB0, 8'hFF, 1'b0, 1'b1, 3);
    run(8'h82, 8'h00, 1'b1, 1'b1, 1);
  endtask
  task automatic t_timeout();
    int n;
    n = 0;
    codeValid = 1'b1;
    codeByte  = 8'h82;
    @(negedge clk) codeByte = 8'h33;
    @(negedge clk) codeValid = 1'b0;
    while (opError !== 1'b1 && n < 10) begin
      @(negedge clk) n++;
      chk("nowr", carryWrEn, 1'b0);
    end
    chk("abort", opError, 1'b1);
    // Bench runs the design with a read limit of four cycles
    chk("tmocyc", n[7:0], 8'h04);
    @(negedge clk);
    chk("idle2", {opError, bitRdReq, opBusy, codeReady}, 4'h1);
  endtask
  // Reset in the middle of a read must abort it and leave the unit usable
  task automatic t_reset();
    codeValid = 1'b1;
    codeByte  = 8'hB0;
    @(negedge clk) codeByte = 8'h44;
    @(negedge clk) codeValid = 1'b0;
    nrst = 1'b0;
    #1 chk("rst", {codeReady, bitRdReq, carryWrEn, opBusy, opDone, opError}, 6'h20);
    chk("rstadr", bitRdAddr, 8'h00);
    @(negedge clk) nrst = 1'b1;
    run(8'h82, 8'h11, 1'b1, 1'b1, 0);
  endtask
  task automatic t_badop();
    codeValid = 1'b1;
    codeByte  = 8'h00;
    @(negedge clk) codeValid = 1'b0;
    chk("idle", {opBusy, bitRdReq, codeReady}, 3'h1);
    run(8'hB0, 8'h5A, 1'b0, 1'b1, 0);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #40000 miscompares++;
    summarize();
  end
  initial begin
    {nrst, codeValid, bitRdValid, bitRdData, carryIn} = '0;
    codeByte = 8'h00;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_truth();
    t_slow();
    t_timeout();
    t_badop();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
